// *** common/usx_consts.vh ***
// Purpose: Register offsets, field positions, reset values and timing for
//          the serial transceiver core.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef USX_CONSTS_VH
`define USX_CONSTS_VH

// Register byte offsets
`define USX_OFF_DATA 12'h000
`define USX_OFF_STATUS 12'h004
`define USX_OFF_CTRL_B 12'h008
`define USX_OFF_CTRL_C 12'h00c
`define USX_OFF_BAUD 12'h010

// Status register bits
`define USX_ST_PAR_ERR 2
`define USX_ST_OVERRUN 3
`define USX_ST_FRAME_ERR 4
`define USX_ST_TX_EMPTY 5
`define USX_ST_TX_DONE 6
`define USX_ST_RX_DONE 7

// Control B bits
`define USX_CB_TX_BIT8 0
`define USX_CB_RX_BIT8 1
`define USX_CB_SIZE2 2
`define USX_CB_TX_EN 3
`define USX_CB_RX_EN 4
`define USX_CB_EMPTY_IE 5
`define USX_CB_TX_DONE_IE 6
`define USX_CB_RX_DONE_IE 7

// Control C bits
`define USX_CC_SYNC 6
`define USX_CC_PAR_EN 5
`define USX_CC_PAR_ODD 4
`define USX_CC_STOP2 3
`define USX_CC_SIZE_HI 2
`define USX_CC_SIZE_LO 1

// Reset values
`define USX_RST_CTRL_C 8'h06
`define USX_RST_BAUD 16'h0000

// Character size code for nine data bits
`define USX_SIZE_NINE 3'h7

// Oversampling ticks per bit and centre sample
`define USX_OVERSAMPLE 16
`define USX_MID_SAMPLE 4'h7

`endif

// *** core/usx_core.v ***
// Purpose: Serial transceiver: transmit flags, parity and shutdown plus the
//          full receive path with a two-entry receive buffer.
// Assumes: APB slave, one clock; pins synchronous to pclk; global interrupt
//          enable supplied as an input from the host core.
// Notes:   Baud divider gives a 16x oversample tick; synchronous mode uses
//          rising edges of the transfer clock pin as the bit tick.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.vh"

// Overview of operation
// R1: Set tx done once shifter empties with no further data buffered.
// R2: Tx done clears on interrupt acknowledge or a written one.
// R3: Tx done interrupt raised with its enable and global enable.
// R4: Buffer-empty interrupt held while enabled and buffer empty.
// R5: Parity bit sent after last data bit, before first stop.
// R6: Transmitter disable waits for shifter and buffer empty; then frees pin.
// R7: Receiver enable takes the input pin; sync mode uses clock pin.
// R8: Frame starts on a valid start bit; second stop bit ignored.
// R9: On first stop bit, frame moves into the receive buffer.
// R10: Unused upper data bits read as zero.
// R11: Ninth bit and error flags stored per frame, advance on read.
// R12: Software reads status and ninth bit before data.
// R13: Rx done reads one while unread data is buffered.
// R14: Rx done interrupt held while flag set and enabled.
// R15: Error flags ignore writes and raise no interrupt.
// R16: Software writes zeros to error flag positions.
// R17: Frame error reflects first stop bit only.
// R18: Overrun when buffer full, shifter holds char, new start bit.
// R19: Overrun clears on a successful transfer into the buffer.
// R20: Parity check only when enabled; odd select; result stored.
// R21: Parity error set only if checked and failed; valid until read.
// R22: Parity error reads zero while checking disabled.
// R23: Receiver disable is immediate: drop frame, flush buffer, free pin.
// R24: Even parity is xor of data; odd inverts it.
// R25: Buffer-empty set when transmit buffer empty, else cleared.
// R26: Odd select low means even parity, high means odd.
module usx_core
(
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Host core interrupt interface
  input wire global_irq_enable,
  input wire tx_done_irq_ack,
  output wire tx_done_irq,
  output wire tx_empty_irq,
  output wire rx_done_irq,
  // Serial pins
  input wire serial_in_pin,
  input wire transfer_clock_pin,
  output reg serial_out_pin,
  output wire serial_out_oe,
  output wire serial_in_owned
);

  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  function parity_of;
    input [8:0] d;
    input odd;
    begin
      parity_of = (^d) ^ odd;
    end
  endfunction

  function [3:0] data_bits;
    input [2:0] sz;
    begin
      if (sz == `USX_SIZE_NINE)
        data_bits = 4'h9;
      else if (sz[2])
        data_bits = 4'h8;
      else
        data_bits = 4'h5 + {2'h0, sz[1:0]};
    end
  endfunction

  function [8:0] size_mask;
    input [3:0] n;
    begin
      size_mask = ~(9'h1ff << n);
    end
  endfunction

  reg tx_bit8, tx_en, rx_en, empty_ie, tx_done_ie, rx_done_ie, size2;
  reg sync_mode, par_en, par_odd, stop2, size_hi, size_lo;
  reg [15:0] baud;
  wire [2:0] size_code = {size2, size_hi, size_lo};
  wire [3:0] nbits = data_bits(size_code);
  wire [8:0] mask = size_mask(nbits);

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire wr_data = wr && paddr == `USX_OFF_DATA;
  wire rd_data = rd && paddr == `USX_OFF_DATA;
  wire wr_stat = wr && paddr == `USX_OFF_STATUS;

  // Bit tick generation
  reg [15:0] baud_cnt;
  reg [3:0] os_cnt;
  reg xck_d;
  wire os_tick = (baud_cnt == 16'h0000);
  wire xck_rise = transfer_clock_pin & ~xck_d;
  wire tx_tick = sync_mode ? xck_rise : (os_tick && os_cnt == 4'hf);
  wire rx_os = sync_mode ? xck_rise : os_tick;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_cnt <= 16'h0000;
      os_cnt <= 4'h0;
      xck_d <= 1'b0;
    end
    else
    begin
      xck_d <= transfer_clock_pin;
      baud_cnt <= os_tick ? baud : baud_cnt - 16'h0001;
      if (os_tick)
        os_cnt <= os_cnt + 4'h1;
    end
  end

  // Transmitter
  reg [1:0] tx_state;
  reg [8:0] tx_buf;
  reg tx_buf_full;
  reg [11:0] tx_sr;
  reg [3:0] tx_left;
  reg tx_done;
  reg tx_active;
  wire tx_load = tx_state == TX_IDLE && tx_buf_full && tx_tick;
  wire tx_last = tx_state == TX_SHIFT && tx_tick && tx_left == 4'h0;
  wire [3:0] frame_len = 4'h1 + nbits + {3'h0, par_en} + 4'h1 +
                         {3'h0, stop2};
  wire [8:0] tx_dat = tx_buf & mask;

  // Frame image, LSB first: start, data, optional parity, stops
  reg [11:0] next_tx_sr;
  always @*
  begin
    next_tx_sr = 12'hfff;
    next_tx_sr[0] = 1'b0;
    next_tx_sr = next_tx_sr & ~({3'h0, ~tx_dat & mask} << 1);
    if (par_en)
      next_tx_sr[nbits + 4'h1] = parity_of(tx_dat, par_odd); // see R5, R24
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      tx_buf <= 9'h000;
      tx_buf_full <= 1'b0;
      tx_sr <= 12'hfff;
      tx_left <= 4'h0;
      tx_done <= 1'b0;
      tx_active <= 1'b0;
      serial_out_pin <= 1'b1;
    end
    else
    begin
      if (wr_data && tx_en)
      begin
        tx_buf <= {tx_bit8, pwdata[7:0]};
        tx_buf_full <= 1'b1;
      end
      else if (tx_load)
        tx_buf_full <= 1'b0; // see R25
      case (tx_state)
        TX_IDLE:
          if (tx_load)
          begin
            tx_sr <= next_tx_sr;
            tx_left <= frame_len;
            tx_state <= TX_SHIFT;
          end
        TX_SHIFT:
          if (tx_tick)
          begin
            serial_out_pin <= tx_sr[0];
            tx_sr <= {1'b1, tx_sr[11:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_last)
              tx_state <= TX_IDLE;
          end
        default:
          tx_state <= TX_IDLE;
      endcase
      // Set once the last stop bit has run its time; set wins over a clear
      if (tx_last && !tx_buf_full)
        tx_done <= 1'b1; // see R1
      else if (tx_done_irq_ack || (wr_stat && pwdata[`USX_ST_TX_DONE]))
        tx_done <= 1'b0; // see R2
      // Pin stays owned until shifter and buffer drain
      if (tx_en)
        tx_active <= 1'b1;
      else if (tx_state == TX_IDLE && !tx_buf_full)
        tx_active <= 1'b0; // see R6
      if (!tx_active)
        serial_out_pin <= 1'b1;
    end
  end
  assign serial_out_oe = tx_active; // see R6

  // Receiver
  reg [1:0] rx_state;
  reg [3:0] rx_phase;
  reg [3:0] rx_idx;
  reg [9:0] rx_sr;
  reg sr_pending;
  reg sr_fe, sr_pe, rx_prev;
  reg overrun_pend;
  // Two-entry buffer: data[8:0], frame err, overrun, parity err
  reg [11:0] rx_mem [0:1];
  reg rd_ptr;
  reg [1:0] rx_count;
  wire [3:0] rx_len = nbits + {3'h0, par_en};
  // Sync mode samples on each rising clock edge; async at the bit centre
  wire rx_sample = sync_mode ? rx_os :
                   (rx_os && rx_phase == `USX_MID_SAMPLE);
  wire buf_full = rx_count == 2'h2;
  wire pop = rd_data && rx_count != 2'h0;
  wire push = sr_pending && (!buf_full || pop);
  wire start_seen = rx_state == RX_IDLE && rx_os && rx_prev &&
                    !serial_in_pin;
  wire [8:0] rx_word = rx_sr[8:0] & mask;
  wire wr_ptr = rd_ptr ^ rx_count[0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_idx <= 4'h0;
      rx_sr <= 10'h000;
      sr_pending <= 1'b0;
      sr_fe <= 1'b0;
      sr_pe <= 1'b0;
      rx_prev <= 1'b1;
      overrun_pend <= 1'b0;
      rd_ptr <= 1'b0;
      rx_count <= 2'h0;
      rx_mem[0] <= 12'h000;
      rx_mem[1] <= 12'h000;
    end
    else if (!rx_en)
    begin
      // Immediate: frame dropped, buffer flushed
      rx_state <= RX_IDLE; // see R23
      sr_pending <= 1'b0;
      overrun_pend <= 1'b0;
      rx_count <= 2'h0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      if (rx_os)
        rx_phase <= rx_phase + 4'h1;
      if (rx_os)
        rx_prev <= serial_in_pin;
      case (rx_state)
        RX_IDLE:
          if (start_seen)
          begin
            rx_phase <= 4'h1;
            rx_state <= sync_mode ? RX_DATA : RX_START; // see R7
            rx_idx <= 4'h0;
            if (sr_pending && buf_full && !pop)
              overrun_pend <= 1'b1; // see R18
          end
        RX_START:
          if (rx_sample)
            // A high centre sample rejects the start as noise
            rx_state <= serial_in_pin ? RX_IDLE : RX_DATA; // see R8
        RX_DATA:
          if (rx_sample)
          begin
            rx_sr[rx_idx] <= serial_in_pin;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == rx_len - 4'h1)
              rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_sample)
          begin
            // Only the first stop bit is looked at
            sr_fe <= ~serial_in_pin; // see R17
            sr_pe <= par_en &&
                     (parity_of(rx_word, par_odd) != rx_sr[nbits]); // see R20
            sr_pending <= 1'b1; // see R9
            rx_state <= RX_IDLE; // see R8
          end
        default:
          rx_state <= RX_IDLE;
      endcase
      if (push)
      begin
        rx_mem[wr_ptr] <= {sr_pe, overrun_pend, sr_fe, rx_word}; // see R11
        overrun_pend <= 1'b0; // see R19
      end
      if (push && !(rx_state == RX_STOP && rx_sample))
        sr_pending <= 1'b0;
      if (pop)
        rd_ptr <= ~rd_ptr; // see R11
      rx_count <= rx_count + {1'b0, push} - {1'b0, pop};
    end
  end

  wire [11:0] head = rx_mem[rd_ptr];
  wire rx_done = rx_en && rx_count != 2'h0; // see R13
  assign serial_in_owned = rx_en; // see R7, R23

  // Error flags track the head entry; writes cannot change them
  wire fe_flag = rx_done & head[9]; // see R15
  wire or_flag = rx_done & head[10];
  wire pe_flag = rx_done & head[11] & par_en; // see R21, R22

  // Interrupts; error flags have none
  assign tx_done_irq = global_irq_enable & tx_done_ie & tx_done; // see R3
  assign tx_empty_irq = global_irq_enable & empty_ie & ~tx_buf_full; // see R4
  assign rx_done_irq = global_irq_enable & rx_done_ie & rx_done; // see R14

  // Control register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {rx_done_ie, tx_done_ie, empty_ie, rx_en, tx_en, size2, tx_bit8} <=
        7'h00;
      {sync_mode, par_en, par_odd, stop2, size_hi, size_lo} <= 6'h03;
      baud <= `USX_RST_BAUD;
    end
    else if (wr)
    begin
      if (paddr == `USX_OFF_CTRL_B)
      begin
        rx_done_ie <= pwdata[`USX_CB_RX_DONE_IE];
        tx_done_ie <= pwdata[`USX_CB_TX_DONE_IE];
        empty_ie <= pwdata[`USX_CB_EMPTY_IE];
        rx_en <= pwdata[`USX_CB_RX_EN];
        tx_en <= pwdata[`USX_CB_TX_EN];
        size2 <= pwdata[`USX_CB_SIZE2];
        tx_bit8 <= pwdata[`USX_CB_TX_BIT8];
      end
      else if (paddr == `USX_OFF_CTRL_C)
      begin
        sync_mode <= pwdata[`USX_CC_SYNC];
        par_en <= pwdata[`USX_CC_PAR_EN];
        par_odd <= pwdata[`USX_CC_PAR_ODD]; // see R26
        stop2 <= pwdata[`USX_CC_STOP2];
        size_hi <= pwdata[`USX_CC_SIZE_HI];
        size_lo <= pwdata[`USX_CC_SIZE_LO];
      end
      else if (paddr == `USX_OFF_BAUD)
        baud <= pwdata[15:0];
    end
  end

  reg [31:0] rdata;
  always @*
  begin
    rdata = 32'h00000000;
    if (paddr == `USX_OFF_DATA)
      rdata = {24'h000000, rx_done ? head[7:0] : 8'h00}; // see R10
    else if (paddr == `USX_OFF_STATUS)
      rdata = {24'h000000, rx_done, tx_done, ~tx_buf_full, fe_flag,
               or_flag, pe_flag, 2'h0};
    else if (paddr == `USX_OFF_CTRL_B)
      rdata = {24'h000000, rx_done_ie, tx_done_ie, empty_ie, rx_en, tx_en,
               size2, rx_done & head[8], tx_bit8};
    else if (paddr == `USX_OFF_CTRL_C)
      rdata = {24'h000000, 1'b0, sync_mode, par_en, par_odd, stop2,
               size_hi, size_lo, 1'b0};
    else if (paddr == `USX_OFF_BAUD)
      rdata = {16'h0000, baud};
  end

  wire mapped = paddr == `USX_OFF_DATA || paddr == `USX_OFF_STATUS ||
                paddr == `USX_OFF_CTRL_B || paddr == `USX_OFF_CTRL_C ||
                paddr == `USX_OFF_BAUD;
  assign prdata = rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule
`default_nettype wire

// *** testbench/usx_core_assertions.sv ***
// Purpose: Port-level checks for the serial transceiver core.
// Assumes: One clock domain, presetn asynchronous and active low.
// Notes:   Attached to the core by the bind after the module.
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.vh"
module usx_core_chk
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupts
  input wire logic global_irq_enable,
  input wire logic tx_done_irq_ack,
  input wire logic tx_done_irq,
  input wire logic tx_empty_irq,
  input wire logic rx_done_irq,
  // Pins
  input wire logic serial_in_pin,
  input wire logic transfer_clock_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic serial_in_owned
);
  wire acc = psel && penable;
  wire gie = global_irq_enable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (acc && paddr > `USX_OFF_BAUD
    |-> pslverr && pready && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_irq_gate: assert property (!gie
    |-> !(tx_done_irq || tx_empty_irq || rx_done_irq))
    else $error("interrupt without global enable");
  a_rx_owner: assert property (acc && pwrite
    && paddr == `USX_OFF_CTRL_B |=> serial_in_owned == $past(pwdata[4]))
    else $error("receive pin ownership wrong");
  a_tx_release: assert property ($fell(serial_out_oe)
    |-> serial_out_pin && $past(serial_out_pin, 8))
    else $error("transmit pin freed mid frame");
  a_done_line: assert property ($rose(tx_done_irq)
    |-> serial_out_pin && $past(serial_out_pin, 8))
    else $error("tx done before stop bit");
  a_done_ack: assert property (tx_done_irq && tx_done_irq_ack
    |=> !tx_done_irq)
    else $error("tx done kept after service");
  a_done_hold: assert property (tx_done_irq && !tx_done_irq_ack
    && !(acc && pwrite) |=> tx_done_irq || !gie)
    else $error("tx done interrupt lost");
  a_empty_hold: assert property (tx_empty_irq
    && !(acc && pwrite) |=> tx_empty_irq || !gie)
    else $error("empty interrupt dropped");
  a_rx_irq_hold: assert property (rx_done_irq && !acc
    |=> rx_done_irq || !gie)
    else $error("rx done interrupt dropped");
endmodule
bind usx_core usx_core_chk chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .global_irq_enable, .tx_done_irq_ack, .tx_done_irq,
  .tx_empty_irq, .rx_done_irq, .serial_in_pin, .transfer_clock_pin,
  .serial_out_pin, .serial_out_oe, .serial_in_owned
);
`default_nettype wire

// *** testbench/usx_remote.sv ***
// Purpose: Far-side serial transceiver model.
// Assumes: Frames of bit_clks pclk per bit, line idle high; a transfer
//          clock pulses mid-bit during frames for synchronous mode.
// Notes:   Errors are injected only when the bench asks.
`timescale 1ns/10ps
`default_nettype none
module usx_remote
#(
  parameter int bit_clks = 16
)
(
  // Serial lines
  input wire logic pclk,
  input wire logic from_dut,
  output var logic to_dut,
  output var logic xck
);
  initial to_dut = 1'h1;
  initial xck = 1'h0;
  // Clock rises mid-bit and stands still between frames
  task automatic put(input logic b);
    begin
      to_dut <= b;
      repeat (bit_clks / 2) @(posedge pclk);
      xck <= 1'h1;
      repeat (bit_clks - bit_clks / 2) @(posedge pclk);
      xck <= 1'h0;
    end
  endtask
  // One stop bit, then idle high as a pulled-up line would be
  task automatic send(input logic [8:0] d, input int n, input logic pen,
    input logic podd, input logic bp, input logic bs);
    int k;
    logic p;
    begin
      p = podd ^ bp;
      @(posedge pclk);
      put(1'h0);
      for (k = 0; k < n; k++)
      begin
        put(d[k]);
        p = p ^ d[k];
      end
      if (pen)
        put(p);
      put(!bs);
      to_dut <= 1'h1;
    end
  endtask
  // Samples each bit at its centre, counted from the start edge
  task automatic grab(input int n, output logic [10:0] bits);
    int k;
    begin
      bits = 11'h0;
      @(posedge pclk);
      while (from_dut !== 1'h0)
        @(posedge pclk);
      repeat (bit_clks / 2) @(posedge pclk);
      for (k = 0; k <= n; k++)
      begin
        repeat (bit_clks) @(posedge pclk);
        bits[k] = from_dut;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/usx_core_tb.sv ***
// Purpose: Self-checking bench for the serial transceiver core.
// Assumes: Baud divider left at 0, so one bit lasts 16 pclk.
// Notes:   Frame rows first, then reset, overrun and shutdown cases.
`timescale 1ns/10ps
`default_nettype none
`include "usx_consts.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s expected %h seen %h", nm, e, g); \
  end end
module usx_core_tb;
  typedef struct {
    logic [8:0] d;
    logic [2:0] sz;
    logic pen, podd, bp, bs;
    logic [8:0] ed;
    logic [2:0] est;
  } usx_row_t;
  // Sent value, size code, parity on/odd, bad parity, bad stop,
  // expected data and expected frame/overrun/parity flags
  usx_row_t rows [5] = '{
    '{9'h0a5, 3'h3, 1'h1, 1'h0, 1'h0, 1'h0, 9'h0a5, 3'h0},
    '{9'h0a5, 3'h3, 1'h1, 1'h1, 1'h1, 1'h0, 9'h0a5, 3'h1},
    '{9'h1f3, 3'h1, 1'h0, 1'h0, 1'h1, 1'h1, 9'h033, 3'h4},
    '{9'h15a, 3'h7, 1'h1, 1'h1, 1'h0, 1'h0, 9'h15a, 3'h0},
    '{9'h017, 3'h0, 1'h1, 1'h0, 1'h1, 1'h1, 9'h017, 3'h5}};
  logic pclk, presetn, psel, penable, pwrite, gie, ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, tx_done_irq, tx_empty_irq, rx_done_irq;
  logic rx_line, tx_line, tx_oe, rx_owned, xck;
  logic [10:0] bits;
  usx_row_t r;
  int failures, comparisons, i, n, w;
  usx_core dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_irq_enable(gie),
    .tx_done_irq_ack(ack), .tx_done_irq(tx_done_irq),
    .tx_empty_irq(tx_empty_irq), .rx_done_irq(rx_done_irq),
    .serial_in_pin(rx_line), .transfer_clock_pin(xck),
    .serial_out_pin(tx_line), .serial_out_oe(tx_oe),
    .serial_in_owned(rx_owned)
  );
  usx_remote #(.bit_clks(16)) remote
  (
    .pclk(pclk), .from_dut(tx_line), .to_dut(rx_line), .xck(xck)
  );
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task automatic wait_st(input int b);
    begin
      w = 0;
      apb(1'h0, `USX_OFF_STATUS, 32'h0);
      while (rd[b] !== 1'h1 && w < 500)
      begin
        apb(1'h0, `USX_OFF_STATUS, 32'h0);
        w++;
      end
      if (w >= 500)
        failures++;
    end
  endtask
  task automatic give_verdict;
    begin
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Whole run is near 3000 cycles; allow about ten times that
  initial
  begin
    #750000;
    failures++;
    give_verdict;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, gie, ack} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    gie <= 1'h1;
    for (i = 0; i < 5; i++)
    begin
      r = rows[i];
      n = (r.sz == `USX_SIZE_NINE) ? 9 : r.sz + 5;
      apb(1'h1, `USX_OFF_CTRL_C,
        {26'h0, r.pen, r.podd, r.bs, r.sz[1:0], 1'h0});
      apb(1'h1, `USX_OFF_CTRL_B, {24'h0, 5'h1f, r.sz[2], 1'h0, r.d[8]});
      fork
        remote.grab(n + r.pen, bits);
        apb(1'h1, `USX_OFF_DATA, {23'h0, r.d});
      join
      `CHK("tx data", r.ed, bits[8:0] & ((9'h1 << n) - 9'h1))
      if (r.pen)
        `CHK("tx parity", ^r.ed ^ r.podd, bits[n])
      `CHK("tx stop", 1'h1, bits[n + r.pen])
      wait_st(`USX_ST_TX_DONE);
      `CHK("tx done", 1'h1, rd[`USX_ST_TX_DONE])
      apb(1'h1, `USX_OFF_STATUS, 32'h40);
      apb(1'h0, `USX_OFF_STATUS, 32'h0);
      `CHK("tx done w1c", 1'h0, rd[`USX_ST_TX_DONE])
      remote.send(r.d, n, r.pen, r.podd, r.bp, r.bs);
      wait_st(`USX_ST_RX_DONE);
      `CHK("rx status", {1'h1, r.est}, {rd[7], rd[4:2]})
      apb(1'h0, `USX_OFF_CTRL_B, 32'h0);
      `CHK("ninth bit", r.ed[8], rd[`USX_CB_RX_BIT8])
      apb(1'h0, `USX_OFF_DATA, 32'h0);
      `CHK("rx data", {24'h0, r.ed[7:0]}, rd)
      apb(1'h0, `USX_OFF_STATUS, 32'h0);
      `CHK("rx empty", 1'h0, rd[`USX_ST_RX_DONE])
    end
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `USX_OFF_CTRL_C, 32'h0);
    `CHK("ctrl c reset", {24'h0, `USX_RST_CTRL_C}, rd)
    apb(1'h0, `USX_OFF_STATUS, 32'h0);
    `CHK("status reset", 32'h20, rd)
    apb(1'h0, 12'h020, 32'h0);
    `CHK("unmapped", {1'h1, 32'h0}, {err, rd})
    apb(1'h1, `USX_OFF_CTRL_B, 32'hf8);
    // Four frames unread: two buffered, one waiting, one more start
    for (i = 1; i < 5; i++)
      remote.send(9'(i), 8, 1'h0, 1'h0, 1'h0, 1'h0);
    apb(1'h1, `USX_OFF_STATUS, 32'h1c);
    apb(1'h0, `USX_OFF_STATUS, 32'h0);
    `CHK("flags unwritable", 3'h0, rd[4:2])
    apb(1'h0, `USX_OFF_DATA, 32'h0);
    `CHK("first frame", 32'h1, rd)
    apb(1'h0, `USX_OFF_STATUS, 32'h0);
    `CHK("second overrun", 1'h0, rd[`USX_ST_OVERRUN])
    apb(1'h0, `USX_OFF_DATA, 32'h0);
    apb(1'h1, `USX_OFF_STATUS, 32'h0);
    apb(1'h0, `USX_OFF_STATUS, 32'h0);
    `CHK("third overrun", 1'h1, rd[`USX_ST_OVERRUN])
    apb(1'h1, `USX_OFF_CTRL_B, 32'he8);
    apb(1'h0, `USX_OFF_STATUS, 32'h0);
    `CHK("flushed", 2'h0, {rd[`USX_ST_RX_DONE], rx_owned})
    apb(1'h1, `USX_OFF_CTRL_B, 32'hf8);
    apb(1'h1, `USX_OFF_CTRL_C, 32'h46);
    remote.send(9'h055, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    wait_st(`USX_ST_RX_DONE);
    `CHK("overrun cleared", 1'h0, rd[`USX_ST_OVERRUN])
    apb(1'h0, `USX_OFF_DATA, 32'h0);
    `CHK("sync frame", 32'h55, rd)
    apb(1'h1, `USX_OFF_CTRL_C, 32'h06);
    fork
      remote.grab(8, bits);
      begin
        apb(1'h1, `USX_OFF_DATA, 32'h3c);
        apb(1'h1, `USX_OFF_CTRL_B, 32'hf0);
        @(posedge pclk);
        `CHK("pin held", 1'h1, tx_oe)
      end
    join
    `CHK("late frame", 9'h13c, bits[8:0])
    w = 0;
    while (tx_oe !== 1'h0 && w < 400)
    begin
      @(posedge pclk);
      w++;
    end
    @(posedge pclk);
    `CHK("irq state", 3'h3, {tx_oe, tx_done_irq, tx_empty_irq})
    ack <= 1'h1;
    @(posedge pclk);
    ack <= 1'h0;
    @(posedge pclk);
    `CHK("serviced", 1'h0, tx_done_irq)
    gie <= 1'h0;
    @(posedge pclk);
    `CHK("irq gated", 3'h0, {tx_done_irq, tx_empty_irq, rx_done_irq})
    gie <= 1'h1;
    @(posedge pclk);
    `CHK("irq regained", 1'h1, tx_empty_irq)
    give_verdict;
  end
endmodule
`default_nettype wire
